// >>> hw/framer_pkg.sv
// constants and state types for the serial update packet framer
package framer_pkg;
    localparam logic [7:0] SIZE_OVERHEAD = 8'h02;
    localparam logic [7:0] ACK_DEFAULT = 8'hCC;
    localparam logic [7:0] NAK_DEFAULT = 8'h33;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_SUM = 2'b01,
        RX_DATA = 2'b10,
        RX_HOLD = 2'b11
    } rx_state_e;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_SIZE = 3'b001,
        TX_SUM = 3'b010,
        TX_DATA = 3'b011,
        TX_WAIT = 3'b100,
        TX_REPLY = 3'b101
    } tx_state_e;
endpackage

// >>> hw/serial_update_packet_framer.sv
// packet framer: receive with verdict-driven reply, send with reply wait
`timescale 1ns/10ps
module serial_update_packet_framer
    import framer_pkg::*;
#(
    parameter logic [7:0] ACK_CODE = ACK_DEFAULT,
    parameter logic [7:0] NAK_CODE = NAK_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    // bytes arriving from the link
    input wire logic [7:0] link_rx_data,
    input wire logic link_rx_valid,
    // bytes leaving onto the link
    output logic [7:0] link_tx_data,
    output logic link_tx_valid,
    input wire logic link_tx_ready,
    // received packet to the consumer
    output logic [7:0] pkt_rx_data,
    output logic pkt_rx_valid,
    output logic pkt_rx_last,
    output logic pkt_rx_sum_ok,
    // consumer verdict; content_ok=0 forces not-acknowledge
    input wire logic verdict_valid,
    input wire logic verdict_content_ok,
    // outgoing packet from the producer
    input wire logic send_start,
    input wire logic [7:0] send_len,
    input wire logic [7:0] send_sum,
    input wire logic [7:0] send_data,
    output logic send_data_ready,
    output logic send_busy,
    output logic send_done,
    output logic send_acked
);
    rx_state_e rx_state_reg, rx_state_next;
    tx_state_e tx_state_reg, tx_state_next;
    logic [7:0] rx_left_reg, rx_left_next;
    logic [7:0] rx_sum_reg, rx_sum_next;
    logic [7:0] rx_acc_reg, rx_acc_next;
    logic [7:0] pkt_data_reg, pkt_data_next;
    logic pkt_valid_reg, pkt_valid_next;
    logic pkt_last_reg, pkt_last_next;
    logic pkt_ok_reg, pkt_ok_next;
    logic [7:0] reply_reg, reply_next;
    logic reply_pend_reg, reply_pend_next;
    logic [7:0] tx_left_reg, tx_left_next;
    logic [7:0] tx_len_reg, tx_len_next;
    logic [7:0] tx_sum_reg, tx_sum_next;
    logic [7:0] tx_out_reg, tx_out_next;
    logic tx_out_v_reg, tx_out_v_next;
    logic done_reg, done_next;
    logic acked_reg, acked_next;
    logic [7:0] acc_sum;
    logic tx_owns_rx;

    // while awaiting a reply, incoming bytes belong to the sender
    assign tx_owns_rx = (tx_state_reg == TX_WAIT);
    assign acc_sum = 8'(rx_acc_reg + link_rx_data);

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_left_next = rx_left_reg;
        rx_sum_next = rx_sum_reg;
        rx_acc_next = rx_acc_reg;
        pkt_data_next = pkt_data_reg;
        pkt_valid_next = 1'b0;
        pkt_last_next = 1'b0;
        pkt_ok_next = pkt_ok_reg;
        reply_next = reply_reg;
        reply_pend_next = reply_pend_reg;
        if (reply_pend_reg && link_tx_valid && link_tx_ready && tx_state_reg == TX_REPLY) begin
            reply_pend_next = 1'b0;
        end
        case (rx_state_reg)
            RX_IDLE: begin
                if (link_rx_valid && !tx_owns_rx && link_rx_data != ZERO_BYTE) begin
                    rx_left_next = 8'(link_rx_data - SIZE_OVERHEAD);
                    rx_acc_next = ZERO_BYTE;
                    rx_state_next = RX_SUM;
                end
            end
            RX_SUM: begin
                if (link_rx_valid) begin
                    rx_sum_next = link_rx_data;
                    rx_state_next = (rx_left_reg == ZERO_BYTE) ? RX_HOLD : RX_DATA;
                    if (rx_left_reg == ZERO_BYTE) begin
                        pkt_ok_next = (link_rx_data == ZERO_BYTE);
                    end
                end
            end
            RX_DATA: begin
                if (link_rx_valid) begin
                    rx_acc_next = acc_sum;
                    pkt_data_next = link_rx_data;
                    pkt_valid_next = 1'b1;
                    rx_left_next = 8'(rx_left_reg - 8'h01);
                    if (rx_left_reg == 8'h01) begin
                        pkt_last_next = 1'b1;
                        pkt_ok_next = (acc_sum == rx_sum_reg);
                        rx_state_next = RX_HOLD;
                    end
                end
            end
            RX_HOLD: begin
                // no reply until the consumer has judged the contents
                if (verdict_valid && !reply_pend_reg) begin
                    reply_next = (pkt_ok_reg && verdict_content_ok) ? ACK_CODE : NAK_CODE;
                    reply_pend_next = 1'b1;
                    rx_state_next = RX_IDLE;
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_state_reg <= RX_IDLE;
            rx_left_reg <= 8'h00;
            rx_sum_reg <= 8'h00;
            rx_acc_reg <= 8'h00;
            pkt_data_reg <= 8'h00;
            pkt_valid_reg <= 1'b0;
            pkt_last_reg <= 1'b0;
            pkt_ok_reg <= 1'b0;
            reply_reg <= 8'h00;
            reply_pend_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_left_reg <= rx_left_next;
            rx_sum_reg <= rx_sum_next;
            rx_acc_reg <= rx_acc_next;
            pkt_data_reg <= pkt_data_next;
            pkt_valid_reg <= pkt_valid_next;
            pkt_last_reg <= pkt_last_next;
            pkt_ok_reg <= pkt_ok_next;
            reply_reg <= reply_next;
            reply_pend_reg <= reply_pend_next;
        end
    end

    // sender: size, checksum, payload, then one reply byte; same layout as receive
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_left_next = tx_left_reg;
        tx_len_next = tx_len_reg;
        tx_sum_next = tx_sum_reg;
        tx_out_next = tx_out_reg;
        tx_out_v_next = tx_out_v_reg;
        done_next = 1'b0;
        acked_next = acked_reg;
        send_data_ready = 1'b0;
        case (tx_state_reg)
            TX_IDLE: begin
                tx_out_v_next = 1'b0;
                // a pending reply goes out before a new packet starts
                if (reply_pend_reg) begin
                    tx_out_next = reply_reg;
                    tx_out_v_next = 1'b1;
                    tx_state_next = TX_REPLY;
                end else if (send_start) begin
                    tx_len_next = send_len;
                    tx_sum_next = send_sum;
                    tx_out_next = 8'(send_len + SIZE_OVERHEAD);
                    tx_out_v_next = 1'b1;
                    tx_state_next = TX_SIZE;
                end
            end
            TX_SIZE: begin
                if (link_tx_ready) begin
                    tx_out_next = tx_sum_reg;
                    tx_state_next = TX_SUM;
                end
            end
            TX_SUM: begin
                if (link_tx_ready) begin
                    tx_left_next = tx_len_reg;
                    tx_out_v_next = 1'b0;
                    tx_state_next = (tx_len_reg == 8'h00) ? TX_WAIT : TX_DATA;
                end
            end
            TX_DATA: begin
                if (!tx_out_v_reg || link_tx_ready) begin
                    if (tx_left_reg == 8'h00) begin
                        tx_out_v_next = 1'b0;
                        tx_state_next = TX_WAIT;
                    end else begin
                        send_data_ready = 1'b1;
                        tx_out_next = send_data;
                        tx_out_v_next = 1'b1;
                        tx_left_next = 8'(tx_left_reg - 8'h01);
                    end
                end
            end
            TX_WAIT: begin
                tx_out_v_next = 1'b0;
                if (link_rx_valid) begin
                    acked_next = (link_rx_data == ACK_CODE);
                    done_next = 1'b1;
                    tx_state_next = TX_IDLE;
                end
            end
            TX_REPLY: begin
                if (link_tx_ready) begin
                    tx_out_v_next = 1'b0;
                    tx_state_next = TX_IDLE;
                end
            end
            default: tx_state_next = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_state_reg <= TX_IDLE;
            tx_left_reg <= 8'h00;
            tx_len_reg <= 8'h00;
            tx_sum_reg <= 8'h00;
            tx_out_reg <= 8'h00;
            tx_out_v_reg <= 1'b0;
            done_reg <= 1'b0;
            acked_reg <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_left_reg <= tx_left_next;
            tx_len_reg <= tx_len_next;
            tx_sum_reg <= tx_sum_next;
            tx_out_reg <= tx_out_next;
            tx_out_v_reg <= tx_out_v_next;
            done_reg <= done_next;
            acked_reg <= acked_next;
        end
    end

    assign link_tx_data = tx_out_reg;
    assign link_tx_valid = tx_out_v_reg;
    assign pkt_rx_data = pkt_data_reg;
    assign pkt_rx_valid = pkt_valid_reg;
    assign pkt_rx_last = pkt_last_reg;
    assign pkt_rx_sum_ok = pkt_ok_reg;
    assign send_busy = (tx_state_reg != TX_IDLE) && (tx_state_reg != TX_REPLY);
    assign send_done = done_reg;
    assign send_acked = acked_reg;

    AST_IDLE_ZERO: assert property (@(posedge clk) disable iff (reset)
        rx_state_reg == RX_IDLE && link_rx_valid && link_rx_data == 8'h00
        |=> rx_state_reg == RX_IDLE)
        else $error("zero byte left idle");
    AST_SIZE_TAKEN: assert property (@(posedge clk) disable iff (reset)
        rx_state_reg == RX_IDLE && link_rx_valid && !tx_owns_rx && link_rx_data != 8'h00
        |=> rx_state_reg == RX_SUM && rx_left_reg == 8'($past(link_rx_data) - 8'h02))
        else $error("size byte not taken");
    AST_LAST_FLAG: assert property (@(posedge clk) disable iff (reset)
        rx_state_reg == RX_DATA && link_rx_valid && rx_left_reg == 8'h01
        |=> pkt_rx_last && pkt_rx_valid && rx_state_reg == RX_HOLD)
        else $error("last payload byte not flagged");
    AST_SUM_CHECK: assert property (@(posedge clk) disable iff (reset)
        rx_state_reg == RX_DATA && link_rx_valid && rx_left_reg == 8'h01
        |=> pkt_rx_sum_ok == ($past(acc_sum) == rx_sum_reg))
        else $error("checksum compare wrong");
    AST_NO_AUTO_REPLY: assert property (@(posedge clk) disable iff (reset)
        rx_state_reg == RX_HOLD && !verdict_valid |=> !$rose(reply_pend_reg))
        else $error("reply without verdict");
    AST_ACK_CODE: assert property (@(posedge clk) disable iff (reset)
        rx_state_reg == RX_HOLD && verdict_valid && !reply_pend_reg && pkt_ok_reg
        && verdict_content_ok |=> reply_pend_reg && reply_reg == ACK_CODE)
        else $error("ack not queued");
    AST_NAK_CODE: assert property (@(posedge clk) disable iff (reset)
        rx_state_reg == RX_HOLD && verdict_valid && !reply_pend_reg && !verdict_content_ok
        |=> reply_reg == NAK_CODE)
        else $error("nak not queued");
    AST_SIZE_OUT: assert property (@(posedge clk) disable iff (reset)
        tx_state_reg == TX_IDLE && !reply_pend_reg && send_start
        |=> link_tx_valid && link_tx_data == 8'($past(send_len) + 8'h02))
        else $error("size byte wrong");
    AST_SUM_AFTER_SIZE: assert property (@(posedge clk) disable iff (reset)
        tx_state_reg == TX_SIZE && link_tx_ready |=> link_tx_data == tx_sum_reg)
        else $error("checksum not second");
    AST_WAIT_REPLY: assert property (@(posedge clk) disable iff (reset)
        tx_state_reg == TX_WAIT && link_rx_valid
        |=> send_done && tx_state_reg == TX_IDLE && send_acked == ($past(link_rx_data) == ACK_CODE))
        else $error("reply byte not consumed");
    AST_CODES: assert property (@(posedge clk) disable iff (reset)
        ACK_CODE != NAK_CODE && ACK_CODE != 8'h00 && NAK_CODE != 8'h00)
        else $error("ack and nak codes invalid");
    COV_RX_PKT: cover property (@(posedge clk) disable iff (reset) pkt_rx_last && pkt_rx_sum_ok);
    COV_RX_BAD: cover property (@(posedge clk) disable iff (reset) pkt_rx_last && !pkt_rx_sum_ok);
    COV_TX_ACK: cover property (@(posedge clk) disable iff (reset) send_done && send_acked);
    COV_TX_NAK: cover property (@(posedge clk) disable iff (reset) send_done && !send_acked);
endmodule

// >>> bench/update_host_model.sv
// far-side update host: feeds the receive path and answers device packets
`timescale 1ns/10ps
module update_host_model
    import framer_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid
);
    logic [7:0] rxq[$];
    logic [7:0] rep_q[$];
    logic [7:0] dev_q[$];
    bit exp_reply = 0;
    bit slow = 0;
    bit force_nak = 0;
    int need = 0;
    initial begin
        tx_ready = 1'b0;
        rx_data = 8'h5A;
        rx_valid = 1'b0;
    end
    // random stalls only in slow mode, so both prompt and slow hosts are seen
    always @(negedge clk) begin
        tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
        if (rxq.size() > 0) begin
            rx_data <= rxq.pop_front();
            rx_valid <= 1'b1;
        end else begin
            rx_data <= ~rx_data; // no stale byte left on the idle line
            rx_valid <= 1'b0;
        end
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            if (exp_reply) begin
                rep_q.push_back(tx_data);
                exp_reply = 0;
            end else begin
                dev_q.push_back(tx_data);
                if (dev_q.size() == 1)
                    need = tx_data;
                if (dev_q.size() == need) // size counts both header bytes
                    rxq.push_back(force_nak ? NAK_DEFAULT : ACK_DEFAULT);
            end
        end
    end
    task automatic put_pkt(input logic [7:0] pay[$], input logic [7:0] bad);
        logic [7:0] s;
        s = 8'h00;
        foreach (pay[i]) s += pay[i];
        rxq.push_back(8'(pay.size() + 2));
        rxq.push_back(s ^ bad);
        foreach (pay[i]) rxq.push_back(pay[i]);
        exp_reply = 1;
    endtask
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the packet framer against a queue model
`timescale 1ns/10ps
module tb_top;
    import framer_pkg::*;
    logic clk = 0;
    logic reset = 1;
    logic [7:0] link_rx_data, link_tx_data, pkt_rx_data;
    logic [7:0] send_len = 8'h00, send_sum = 8'h00, send_data = 8'h00;
    logic link_rx_valid, link_tx_valid, link_tx_ready, pkt_rx_valid, pkt_rx_last;
    logic pkt_rx_sum_ok, send_data_ready, send_busy, send_done, send_acked;
    logic verdict_valid = 0, verdict_content_ok = 0, send_start = 0;
    int fail_count = 0, checks_done = 0, idx = 0, nlast = 0;
    logic [7:0] got_q[$], pay[$];
    always #10 clk = ~clk;
    serial_update_packet_framer DUT (.clk(clk), .reset(reset),
        .link_rx_data(link_rx_data), .link_rx_valid(link_rx_valid),
        .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid),
        .link_tx_ready(link_tx_ready), .pkt_rx_data(pkt_rx_data),
        .pkt_rx_valid(pkt_rx_valid), .pkt_rx_last(pkt_rx_last),
        .pkt_rx_sum_ok(pkt_rx_sum_ok), .verdict_valid(verdict_valid),
        .verdict_content_ok(verdict_content_ok), .send_start(send_start),
        .send_len(send_len), .send_sum(send_sum), .send_data(send_data),
        .send_data_ready(send_data_ready), .send_busy(send_busy),
        .send_done(send_done), .send_acked(send_acked));
    update_host_model host (.clk(clk), .tx_data(link_tx_data), .tx_valid(link_tx_valid),
        .tx_ready(link_tx_ready), .rx_data(link_rx_data), .rx_valid(link_rx_valid));
    always @(posedge clk) begin
        if (pkt_rx_valid)
            got_q.push_back(pkt_rx_data);
        if (pkt_rx_last)
            nlast++;
        if (send_data_ready)
            idx++;
    end
    always @(negedge clk)
        send_data <= (idx < pay.size()) ? pay[idx] : 8'h00;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic fill(input int n, output logic [7:0] s);
        pay.delete();
        s = 8'h00;
        for (int i = 0; i < n; i++)
            pay.push_back(8'($urandom_range(0, 255)));
        foreach (pay[i]) s += pay[i];
    endtask
    task automatic rx_test(input int n, input logic [7:0] bad, input logic ok);
        logic [7:0] s;
        fill(n, s);
        got_q.delete();
        nlast = 0;
        repeat ($urandom_range(0, 3)) host.rxq.push_back(8'h00);
        host.put_pkt(pay, bad);
        for (int k = 0; k < 300 && host.rxq.size() > 0; k++) @(negedge clk);
        repeat (4) @(negedge clk);
        chk(8'(got_q.size()), 8'(n));
        foreach (pay[i]) chk(got_q[i], pay[i]);
        chk({7'h00, pkt_rx_sum_ok}, {7'h00, bad == 8'h00});
        chk(8'(nlast), 8'(n > 0));
        chk(8'(host.rep_q.size()), 8'h00);
        verdict_valid <= 1'b1;
        verdict_content_ok <= ok;
        @(negedge clk);
        verdict_valid <= 1'b0;
        for (int k = 0; k < 300 && host.rep_q.size() == 0; k++) @(negedge clk);
        chk(host.rep_q.pop_front(), (bad == 8'h00 && ok) ? ACK_DEFAULT : NAK_DEFAULT);
        $display("receive test done, %0d payload bytes", n);
    endtask
    task automatic tx_test(input int n, input bit nak);
        logic [7:0] s;
        fill(n, s);
        host.dev_q.delete();
        host.force_nak = nak;
        idx = 0;
        send_len <= 8'(n);
        send_sum <= s;
        send_start <= 1'b1;
        @(negedge clk);
        send_start <= 1'b0;
        chk({7'h00, send_busy}, 8'h01);
        for (int k = 0; k < 2000 && send_done !== 1'b1; k++) @(negedge clk);
        chk({7'h00, send_done}, 8'h01);
        chk({7'h00, send_busy}, 8'h00);
        chk({7'h00, send_acked}, {7'h00, !nak});
        chk(8'(host.dev_q.size()), 8'(n + 2));
        chk(host.dev_q[0], 8'(n + 2));
        chk(host.dev_q[1], s);
        foreach (pay[i]) chk(host.dev_q[i + 2], pay[i]);
        repeat (3) @(negedge clk);
        $display("send test done, %0d payload bytes", n);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        void'($urandom(22018));
        repeat (2) @(negedge clk);
        reset <= 1'b0;
        @(negedge clk);
        rx_test(1, 8'h00, 1'b1);
        rx_test(0, 8'h00, 1'b1);
        rx_test(5, 8'h01, 1'b1);
        rx_test(3, 8'h00, 1'b0);
        tx_test(4, 1'b0);
        tx_test(2, 1'b1);
        host.slow = 1;
        // stalls on the link while both directions alternate
        for (int t = 0; t < 8; t++) begin
            rx_test($urandom_range(0, 9), 8'($urandom_range(0, 1)), 1'($urandom_range(0, 1)));
            tx_test($urandom_range(0, 9), 1'($urandom_range(0, 1)));
        end
        print_verdict();
    end
    // whole run needs a few hundred cycles; this cuts a hang short
    initial begin
        #(20 * 50000);
        fail_count++;
        print_verdict();
    end
endmodule
